// >>> verilog/fsl_host.sv
`timescale 1ns/100ps
module fsl_host import fsl_pkg::*; #(
  parameter int unsigned POR_WAIT = POR_CYC
) (
  input wire logic pclk, // Bus clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic [20:0] fl_addr, // Flash address lines.
  output logic [15:0] fl_dq_o, // Flash data out.
  output logic fl_dq_oe, // Flash data drive enable.
  input wire logic [15:0] fl_dq_i, // Flash data in.
  output logic fl_ce_n, // Flash chip enable.
  output logic fl_oe_n, // Flash output enable.
  output logic fl_we_n, // Flash write enable.
  output logic fl_rst_n, // Flash reset pin.
  input wire logic fl_rdy_i // Flash ready/busy, open drain.
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  fsl_state_t state_q;
  logic [2:0] step_q;
  logic [4:0] tcnt_q;
  logic [3:0] cmd_q;
  logic [20:0] addr_q;
  logic [15:0] wdata_q, rdata_q;
  logic [1:0] cfg_q;
  logic fail_q, vpp_q, refused_q, susp_q, susp_chip_q, last_chip_q;
  logic frst_q, have_q, cmp_q, stop_q, tog_q;
  logic [15:0] dq_s1_q, dq_s2_q;
  logic rdy_s1_q, rdy_s2_q;
  logic [31:0] por_q;
  logic por_done, wr, start, wr_end, rd_end, cap, last_step, refuse;
  logic is_wr_cmd, poll_cmd;
  logic [36:0] word;

  assign por_done = (por_q >= POR_WAIT);
  assign wr = psel && penable && pwrite;
  assign start = wr && (paddr == REG_CMD) && (state_q == ST_IDLE);
  assign wr_end = (tcnt_q == WR_END);
  assign rd_end = (tcnt_q == RD_END);
  assign cap = (state_q == ST_RD || state_q == ST_POLL) && tcnt_q == RD_SMP;
  assign is_wr_cmd = !(pwdata[3:0] == CMD_READ || pwdata[3:0] == CMD_IDRD);
  assign poll_cmd = cmd_q == CMD_PROG || cmd_q == CMD_SERASE ||
    cmd_q == CMD_CERASE || cmd_q == CMD_SECPROG ||
    cmd_q == CMD_SECLOCK || cmd_q == CMD_SUSP || cmd_q == CMD_RESUME;

  // Refuse erases during a suspend, programs during a chip erase
  // suspend, any command but a read or an identification read before the power-on wait, codes
  // beyond the table.
  assign refuse = (pwdata[3:0] > CMD_EXIT) || (!por_done && is_wr_cmd) ||
    (susp_q && (pwdata[3:0] == CMD_SERASE ||
    pwdata[3:0] == CMD_CERASE)) ||
    (susp_chip_q && pwdata[3:0] == CMD_PROG);

  // ----------------------------------------------------------------
  // Command sequence tables
  // ----------------------------------------------------------------
  // Last write index of each unlock-prefixed sequence.
  function automatic logic [2:0] last_idx(input logic [3:0] c);
    logic [2:0] n;
    n = 3'h5;
    if (c == CMD_SUSP || c == CMD_RESUME) n = 3'h0;
    else if (c == CMD_IDRD) n = 3'h2;
    else if (c == CMD_PROG || c == CMD_CFG || c == CMD_SECPROG ||
             c == CMD_SECLOCK) n = 3'h3;
    return n;
  endfunction : last_idx

  function automatic logic [36:0] seq_word(input logic [3:0] c,
    input logic [2:0] s, input logic [20:0] a, input logic [15:0] d);
    logic [36:0] w;
    logic [15:0] k;
    w = {ADR_UNL1, DAT_UNL1};
    k = CD_ERASE;
    if (c == CMD_PROG) k = CD_PROG;
    else if (c == CMD_IDRD) k = CD_ID;
    else if (c == CMD_CFG) k = CD_CFG;
    else if (c == CMD_SECPROG || c == CMD_SECLOCK) k = CD_SEC;
    case (s)
      3'h0: begin
        if (c == CMD_SUSP) w = {ADR_UNL1, CD_SUSP};
        else if (c == CMD_RESUME) w = {ADR_UNL1, CD_RESUME};
      end
      3'h1: w = {ADR_UNL2, DAT_UNL2};
      3'h2: w = {ADR_UNL1, k};
      3'h3: begin
        if (c == CMD_SECLOCK) w = {ADR_SECLK, DAT_SECLK};
        else if (c != CMD_SERASE && c != CMD_CERASE && c != CMD_LOCKDN)
          w = {a, d};
      end
      3'h4: w = {ADR_UNL2, DAT_UNL2};
      default: begin
        if (c == CMD_CERASE) w = {ADR_UNL1, CD_CHIP};
        else if (c == CMD_LOCKDN) w = {a, CD_LOCK};
        else w = {a, CD_SECT};
      end
    endcase
    return w;
  endfunction : seq_word

  assign last_step = (step_q == last_idx(cmd_q));
  assign word = (state_q == ST_EXIT) ? {ADR_UNL1, CD_EXIT} :
    (state_q == ST_WR) ? seq_word(cmd_q, step_q, addr_q, wdata_q) :
    {addr_q, wdata_q};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Polling reads the toggle bit until two reads agree; this works
  // for both status settings, where bit seven differs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      step_q <= 3'h0;
      tcnt_q <= 5'h00;
      cmd_q <= CMD_READ;
    end else begin
      tcnt_q <= (state_q == ST_IDLE) ? 5'h00 : tcnt_q + 5'h01;
      case (state_q)
        ST_IDLE: begin
          step_q <= 3'h0;
          if (start && !refuse) begin
            cmd_q <= pwdata[3:0];
            if (pwdata[3:0] == CMD_READ) state_q <= ST_RD;
            else if (pwdata[3:0] == CMD_EXIT) state_q <= ST_EXIT;
            else state_q <= ST_WR;
          end
        end
        ST_WR: begin
          if (wr_end) begin
            tcnt_q <= 5'h00;
            step_q <= step_q + 3'h1;
            if (last_step) begin
              if (cmd_q == CMD_IDRD) state_q <= ST_RD;
              else if (poll_cmd) state_q <= ST_POLL;
              else state_q <= ST_IDLE;
            end
          end
        end
        ST_RD: begin
          if (rd_end) begin
            tcnt_q <= 5'h00;
            state_q <= (cmd_q == CMD_IDRD) ? ST_EXIT : ST_IDLE;
          end
        end
        ST_POLL: begin
          if (rd_end) begin
            tcnt_q <= 5'h00;
            if (stop_q) begin
              if (cmd_q != CMD_SUSP && (fail_q || vpp_q))
                state_q <= ST_EXIT;
              else if (cmd_q != CMD_SUSP && cfg_q == CFG_01)
                state_q <= ST_EXIT;
              else state_q <= ST_IDLE;
            end
          end
        end
        ST_EXIT: begin
          if (wr_end) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Toggle comparison and captured data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 16'h0000;
      have_q <= 1'b0;
      cmp_q <= 1'b0;
      stop_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE) have_q <= 1'b0;
      if (state_q == ST_IDLE) cmp_q <= 1'b0;
      if (cap) begin
        rdata_q <= dq_s2_q;
        tog_q <= dq_s2_q[BIT_TOG];
        have_q <= 1'b1;
        cmp_q <= have_q;
        stop_q <= have_q && (dq_s2_q[BIT_TOG] == tog_q);
      end else if (state_q != ST_POLL) begin
        stop_q <= 1'b0;
      end
    end
  end

  // Outcome flags; a new command clears them and sets refused if refused, a fail read sets fail and supply.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q <= 1'b0;
      vpp_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (start) begin
        refused_q <= refuse;
        fail_q <= 1'b0;
        vpp_q <= 1'b0;
      end else if (cap && state_q == ST_POLL && cmd_q != CMD_SUSP &&
                   have_q && (dq_s2_q[BIT_TOG] != tog_q || !cmp_q)) begin
        // Judge the read before this one: it was status if it opened
        // the poll or the toggle still moved after it. A clean finish
        // returns array data, which must not be taken as flags. An
        // operation already over at the first read is judged on data.
        fail_q <= rdata_q[BIT_FAIL];
        vpp_q <= rdata_q[BIT_VPP];
      end
    end
  end

  // Suspend tracking; a flash reset ends any suspended operation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      susp_q <= 1'b0;
      susp_chip_q <= 1'b0;
      last_chip_q <= 1'b0;
    end else if (frst_q) begin
      susp_q <= 1'b0;
      susp_chip_q <= 1'b0;
    end else if (state_q == ST_IDLE && start && !refuse) begin
      if (pwdata[3:0] == CMD_SERASE) last_chip_q <= 1'b0;
      if (pwdata[3:0] == CMD_CERASE) last_chip_q <= 1'b1;
      if (pwdata[3:0] == CMD_RESUME) begin
        susp_q <= 1'b0;
        susp_chip_q <= 1'b0;
      end
    end else if (state_q == ST_POLL && rd_end && stop_q &&
                 cmd_q == CMD_SUSP) begin
      susp_q <= 1'b1;
      susp_chip_q <= last_chip_q;
    end
  end

  // Host shadow of the status setting; no reset but presetn moves it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_q <= CFG_00;
    else if (state_q == ST_WR && wr_end && last_step && cmd_q == CMD_CFG)
      cfg_q <= {1'b0, wdata_q[0]};
  end

  // Software copies of address, write data and the flash reset pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 21'h000000;
      wdata_q <= 16'h0000;
      frst_q <= 1'b0;
    end else if (wr && state_q == ST_IDLE) begin
      if (paddr == REG_ADDR) addr_q <= pwdata[20:0];
      if (paddr == REG_WDATA) wdata_q <= pwdata[15:0];
      if (paddr == REG_CTRL) frst_q <= pwdata[0];
    end
  end

  // Power-on wait before any program or erase may start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) por_q <= 32'h00000000;
    else if (!por_done) por_q <= por_q + 32'h00000001;
  end

  // Pin inputs arrive asynchronously; two flops before any use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end else begin
      dq_s1_q <= fl_dq_i;
      dq_s2_q <= dq_s1_q;
      rdy_s1_q <= fl_rdy_i;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Flash strobes
  // ----------------------------------------------------------------
  // Write enable never overlaps output enable, so a stray program
  // cannot happen during a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_dq_oe <= 1'b0;
      fl_addr <= 21'h000000;
      fl_dq_o <= 16'h0000;
      fl_rst_n <= 1'b0;
    end else begin
      fl_rst_n <= !frst_q;
      fl_addr <= word[36:16];
      fl_dq_o <= word[15:0];
      if (state_q == ST_WR || state_q == ST_EXIT) begin
        fl_ce_n <= !(tcnt_q < WR_END);
        fl_oe_n <= 1'b1;
        fl_we_n <= !(tcnt_q >= WR_WE_ON && tcnt_q < WR_WE_OFF);
        fl_dq_oe <= (tcnt_q < WR_END);
      end else if (state_q == ST_RD || state_q == ST_POLL) begin
        fl_ce_n <= !(tcnt_q < RD_END);
        fl_oe_n <= !(tcnt_q < RD_END);
        fl_we_n <= 1'b1;
        fl_dq_oe <= 1'b0;
      end else begin
        fl_ce_n <= 1'b1;
        fl_oe_n <= 1'b1;
        fl_we_n <= 1'b1;
        fl_dq_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == REG_CMD ||
    paddr == REG_ADDR || paddr == REG_WDATA || paddr == REG_STAT ||
    paddr == REG_RDATA || paddr == REG_CTRL);
  always_comb begin
    prdata = 32'h00000000;
    case (paddr)
      REG_CMD: prdata = {28'h0000000, cmd_q};
      REG_ADDR: prdata = {11'h000, addr_q};
      REG_WDATA: prdata = {16'h0000, wdata_q};
      REG_STAT: prdata = {23'h000000, cfg_q, rdy_s2_q, por_done,
        susp_q, refused_q, vpp_q, fail_q, (state_q != ST_IDLE)};
      REG_RDATA: prdata = {16'h0000, rdata_q};
      REG_CTRL: prdata = {31'h00000000, frst_q};
      default: prdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence we_pulse_s;
    $fell(fl_we_n) ##0 (!fl_we_n && !fl_ce_n)[*8] ##1 fl_we_n;
  endsequence
  we_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fl_we_n) |-> we_pulse_s) else $error("write pulse width wrong");
  we_oe_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    !fl_we_n |-> fl_oe_n && fl_dq_oe) else $error("write during read");
  read_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    !fl_oe_n |-> !fl_dq_oe) else $error("driving data while reading");
  erase_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
    start && susp_q && pwdata[3:0] == CMD_SERASE |=>
    state_q == ST_IDLE && refused_q) else $error("erase while suspended");
  por_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    !por_done && state_q == ST_WR |->
    cmd_q == CMD_IDRD) else $error("program before power-on wait");
  cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$stable(cfg_q) |-> $past(cmd_q) == CMD_CFG)
    else $error("status setting changed without command");
  fail_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_POLL && rd_end && stop_q && fail_q && cmd_q != CMD_SUSP
    |=> state_q == ST_EXIT) else $error("no exit after fail");
  idrd_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_RD && rd_end && cmd_q == CMD_IDRD |=>
    state_q == ST_EXIT ##[1:20] state_q == ST_IDLE)
    else $error("identification not exited");
  seclock_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    !fl_we_n && state_q == ST_WR && cmd_q == CMD_SECLOCK &&
    step_q == 3'h3 |-> !fl_dq_o[1]) else $error("lock bit not zero");
endmodule : fsl_host

// >>> pkg/fsl_pkg.sv
// Overview of operation
// - After fail, host issues identification exit
// - Supply fault flag; host then issues exit
// - No sector erase while erase suspended
// - Chip erase suspend: reads only, protected sectors; host refuses only programs and erases, reads any sector
// - Four-cycle lock with lock_data_bit zero
// - Host exits identification after security reads
package fsl_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned T_WP_NS = 40;
  localparam int unsigned T_ACC_NS = 70;
  localparam int unsigned T_POR_MS = 10;
  localparam int unsigned WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned POR_CYC = T_POR_MS * CLK_MHZ * 1000;
  // Bus cycle phase points, counted from the start of a cycle.
  localparam logic [4:0] WR_WE_ON = 5'h01;
  localparam logic [4:0] WR_WE_OFF = 5'(WP_CYC + 1);
  localparam logic [4:0] WR_END = 5'(WP_CYC + 3);
  localparam logic [4:0] RD_SMP = 5'(ACC_CYC + 3);
  localparam logic [4:0] RD_END = 5'(ACC_CYC + 4);
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  // ----------------------------------------------------------------
  // Host commands
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic [3:0] CMD_PROG = 4'h1;
  localparam logic [3:0] CMD_SERASE = 4'h2;
  localparam logic [3:0] CMD_CERASE = 4'h3;
  localparam logic [3:0] CMD_LOCKDN = 4'h4;
  localparam logic [3:0] CMD_SUSP = 4'h5;
  localparam logic [3:0] CMD_RESUME = 4'h6;
  localparam logic [3:0] CMD_IDRD = 4'h7;
  localparam logic [3:0] CMD_CFG = 4'h8;
  localparam logic [3:0] CMD_SECPROG = 4'h9;
  localparam logic [3:0] CMD_SECLOCK = 4'hA;
  localparam logic [3:0] CMD_EXIT = 4'hB;
  // ----------------------------------------------------------------
  // Flash bus codes
  // ----------------------------------------------------------------
  localparam logic [20:0] ADR_UNL1 = 21'h000555;
  localparam logic [20:0] ADR_UNL2 = 21'h000AAA;
  localparam logic [20:0] ADR_SECLK = 21'h000080;
  localparam logic [15:0] DAT_UNL1 = 16'h00AA;
  localparam logic [15:0] DAT_UNL2 = 16'h0055;
  localparam logic [15:0] DAT_SECLK = 16'h0000;
  localparam logic [15:0] CD_PROG = 16'h00A0;
  localparam logic [15:0] CD_ERASE = 16'h0080;
  localparam logic [15:0] CD_CHIP = 16'h0010;
  localparam logic [15:0] CD_SECT = 16'h0030;
  localparam logic [15:0] CD_LOCK = 16'h0060;
  localparam logic [15:0] CD_SUSP = 16'h00B0;
  localparam logic [15:0] CD_RESUME = 16'h0030;
  localparam logic [15:0] CD_ID = 16'h0090;
  localparam logic [15:0] CD_EXIT = 16'h00F0;
  localparam logic [15:0] CD_CFG = 16'h00D0;
  localparam logic [15:0] CD_SEC = 16'h00C0;
  // Status bit positions on the data lines.
  localparam int unsigned BIT_TOG = 6;
  localparam int unsigned BIT_FAIL = 5;
  localparam int unsigned BIT_VPP = 3;
  localparam logic [1:0] CFG_00 = 2'h0;
  localparam logic [1:0] CFG_01 = 2'h1;
  typedef enum logic [2:0] {ST_IDLE, ST_WR, ST_RD, ST_POLL, ST_EXIT}
    fsl_state_t;
endpackage : fsl_pkg

// >>> dv/fsl_flash_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Behavioural flash array answering the host strobes.
// ----------------------------------------------------------------
module fsl_flash_model #(
  parameter int PROG_NS = 1000, // Internal word program time.
  parameter int ERASE_NS = 3000 // Internal sector erase time.
) (
  input wire logic [20:0] addr, // Address lines.
  input wire logic [15:0] din, // Data driven by the host.
  input wire logic ce_n, // Chip enable.
  input wire logic oe_n, // Output enable.
  input wire logic we_n, // Write enable.
  input wire logic rst_n, // Reset pin.
  input wire logic vpp_low, // Programming supply too low.
  output logic [15:0] dout, // Data towards the host.
  output logic rdy_low // Pulls the ready/busy line low.
);
  logic [15:0] mem [int];
  logic [63:0] lk = '0;
  logic [1:0] cfg = 2'h0; // Power-up value; the reset pin leaves it.
  logic busy = 1'b0;
  logic sus = 1'b0;
  logic sec_lk = 1'b0; // Security half B locked against writes.
  logic rd_n;
  logic er = 1'b0;
  logic stm = 1'b0;
  logic idm = 1'b0;
  logic fl = 1'b0;
  logic vp = 1'b0;
  logic tg = 1'b0;
  logic [15:0] pd = '0;
  logic [15:0] last = '0;
  int pa = 0;
  int seq = 0;
  int pend = 0;
  int rem = 0;

  // Status answers any address, so a poll at a stale address still ends.
  function automatic logic [15:0] rd(int a);
    if (stm || (busy && !sus))
      return {8'h00, busy ? ((cfg[0] | er) ? 1'b0 : ~pd[7]) : 1'b1,
              tg, fl, 1'b0, vp, 3'h0};
    if (idm && a[7:0] == 8'h80) return {14'h0, !sec_lk, 1'b0};
    if (idm)
      return (a[7:0] == 8'h02) ? {15'h0, lk[a[20:15]]} : 16'h0000;
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : rd

  // Protected sector or weak supply ends at once in status mode.
  task automatic start(int a, logic [15:0] d, logic e);
    pa = a;
    pd = d;
    er = e;
    if (lk[a[20:15]]) begin
      stm = 1'b1;
      fl = 1'b1;
    end else if (vpp_low) begin
      stm = 1'b1;
      vp = 1'b1;
    end else begin
      busy = 1'b1;
      rem = e ? ERASE_NS : PROG_NS;
    end
  endtask : start

  // Command decoder, one call per completed write strobe.
  task automatic wr(int a, logic [15:0] d);
    logic [7:0] c;
    c = d[7:0];
    if (busy) begin
      if (c == 8'hB0) sus = 1'b1;
      else if (c == 8'h30) sus = 1'b0;
    end else if (pend != 0) begin
      if (pend == 1) start(a, d, 1'b0);
      if (pend == 2 && a[7:0] == 8'h80 && !d[1]) sec_lk = 1'b1;
      if (pend == 3) cfg = {1'b0, d[0]};
      pend = 0;
    end else if (c == 8'hF0) begin
      stm = 1'b0;
      idm = 1'b0;
      fl = 1'b0;
      vp = 1'b0;
      seq = 0;
    end else if (seq == 5) begin
      if (c == 8'h30) start(a, d, 1'b1);
      if (c == 8'h60) lk[a[20:15]] = 1'b1;
      seq = 0;
    end else if (c == 8'hAA && (seq == 0 || seq == 3)) seq++;
    else if (c == 8'h55 && (seq == 1 || seq == 4)) seq++;
    else if (seq == 2) begin
      seq = (c == 8'h80) ? 3 : 0;
      pend = (c == 8'hA0) ? 1 : (c == 8'hD0) ? 3 : (c == 8'hC0) ? 2 : 0;
      if (c == 8'h90) idm = 1'b1;
    end else seq = 0;
  endtask : wr

  // Writes count only with chip enabled and outputs off.
  always @(posedge we_n) if (!ce_n && oe_n && rst_n) wr(addr, din);

  // Each read start flips the toggle bit while work runs; both strobes
  // fall in one time step, so the edge is taken from their union.
  assign rd_n = ce_n | oe_n;
  always @(negedge rd_n) if (busy) tg <= ~tg;

  // Internal timer; halts at once when suspended.
  always #10 begin
    if (busy && !sus) rem = rem - 10;
    if (busy && rem <= 0) begin
      busy = 1'b0;
      stm = cfg[0];
      if (!er) mem[pa] = mem.exists(pa) ? mem[pa] & pd : pd;
      else foreach (mem[k]) if (k[20:15] == pa[20:15]) mem[k] = 16'hFFFF;
    end
  end

  // Released data lines show the inverse, never a stale copy.
  always #2 begin
    if (!ce_n && !oe_n) last = rd(addr);
    dout = (!ce_n && !oe_n) ? last : ~last;
  end

  // Reset pin unlocks every sector and aborts work.
  always @(negedge rst_n) begin
    lk = '0;
    busy = 1'b0;
    sus = 1'b0;
    stm = 1'b0;
    idm = 1'b0;
    seq = 0;
    pend = 0;
  end

  assign rdy_low = busy && !sus;
endmodule : fsl_flash_model

// >>> dv/fsl_host_tb_top.sv
`timescale 1ns/100ps
module fsl_host_tb_top;
  import fsl_pkg::*;
  localparam int unsigned POR_SIM = 50;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n;
  logic [20:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i, mdl_dq;
  logic mdl_busy;
  logic vpp_low = 1'b0;
  logic [31:0] rv;
  logic err;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  // Open-drain ready/busy with a pull-up; host drive wins the data lines.
  assign fl_dq_i = fl_dq_oe ? fl_dq_o : mdl_dq;

  initial forever #2.5 pclk = ~pclk;

  fsl_host #(.POR_WAIT(POR_SIM)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n), .fl_rdy_i(!mdl_busy));

  fsl_flash_model mdl (.addr(fl_addr), .din(fl_dq_o), .ce_n(fl_ce_n),
    .oe_n(fl_oe_n), .we_n(fl_we_n), .rst_n(fl_rst_n), .vpp_low(vpp_low),
    .dout(mdl_dq), .rdy_low(mdl_busy));

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; read data is taken at the ready edge only.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Start a command, then poll busy; leaves the status word in rv.
  task automatic run(logic [3:0] c, logic [20:0] a, logic [15:0] d);
    int n;
    n = 0;
    apb(1'b1, REG_ADDR, {11'h0, a});
    apb(1'b1, REG_WDATA, {16'h0, d});
    apb(1'b1, REG_CMD, {28'h0, c});
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rv[0] !== 1'b0 && n < 3000);
    chk("idle", rv[0], 1'b0);
  endtask : run

  task automatic rdd(logic [3:0] c, logic [20:0] a);
    run(c, a, 16'h0);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask : rdd

  task automatic t_por;
    apb(1'b1, REG_CMD, {28'h0, CMD_PROG});
    apb(1'b0, REG_STAT, 32'h0);
    chk("refused", rv[3], 1'b1);
    repeat (POR_SIM) @(posedge pclk);
    apb(1'b0, REG_STAT, 32'h0);
    chk("por_done", rv[5], 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", err, 1'b1);
    $display("test por done");
  endtask : t_por

  task automatic t_prog_erase;
    run(CMD_PROG, 21'h001000, 16'hA55A);
    chk("prog flags", rv[2:1], 2'h0);
    rdd(CMD_READ, 21'h001000);
    chk("prog data", rv, 32'h0000A55A);
    run(CMD_SERASE, 21'h001000, 16'h0);
    chk("erase flags", rv[2:1], 2'h0);
    rdd(CMD_READ, 21'h001000);
    chk("erase data", rv, 32'h0000FFFF);
    $display("test prog_erase done");
  endtask : t_prog_erase

  task automatic t_lock;
    run(CMD_LOCKDN, 21'h010000, 16'h0);
    run(CMD_PROG, 21'h010004, 16'h1234);
    chk("locked fail", rv[1], 1'b1);
    rdd(CMD_READ, 21'h010004);
    chk("locked data", rv, 32'h0000FFFF);
    rdd(CMD_IDRD, 21'h010002);
    chk("lock bit", rv[0], 1'b1);
    rdd(CMD_IDRD, 21'h001002);
    chk("free bit", rv[0], 1'b0);
    $display("test lock done");
  endtask : t_lock

  task automatic t_cfg_reset;
    run(CMD_CFG, 21'h000000, 16'h0001);
    chk("config", rv[8:7], CFG_01);
    run(CMD_PROG, 21'h002000, 16'h00FF);
    chk("cfg01 fail", rv[1], 1'b0);
    rdd(CMD_READ, 21'h002000);
    chk("cfg01 data", rv, 32'h000000FF);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_CTRL, 32'h0);
    run(CMD_PROG, 21'h010004, 16'h1234);
    chk("unlock fail", rv[1], 1'b0);
    chk("config kept", rv[8:7], CFG_01);
    rdd(CMD_READ, 21'h010004);
    chk("unlock data", rv, 32'h00001234);
    $display("test cfg_reset done");
  endtask : t_cfg_reset

  task automatic t_vpp;
    @(posedge pclk);
    vpp_low <= 1'b1;
    run(CMD_PROG, 21'h003000, 16'h1111);
    chk("supply flag", rv[2], 1'b1);
    vpp_low <= 1'b0;
    rdd(CMD_READ, 21'h003000);
    chk("supply data", rv, 32'h0000FFFF);
    $display("test vpp done");
  endtask : t_vpp

  // Suspend with nothing running still sets the host's suspend state.
  task automatic t_susp;
    run(CMD_SUSP, 21'h001000, 16'h0);
    chk("suspended", rv[4], 1'b1);
    run(CMD_SERASE, 21'h001000, 16'h0);
    chk("erase held", rv[3], 1'b1);
    run(CMD_RESUME, 21'h001000, 16'h0);
    chk("resumed", rv[4], 1'b0);
    run(CMD_CERASE, 21'h001000, 16'h0);
    run(CMD_SUSP, 21'h001000, 16'h0);
    run(CMD_PROG, 21'h004000, 16'h0001);
    chk("prog held", rv[3], 1'b1);
    run(CMD_RESUME, 21'h001000, 16'h0);
    chk("chip resumed", rv[4], 1'b0);
    $display("test susp done");
  endtask : t_susp

  task automatic t_sec;
    rdd(CMD_IDRD, 21'h000080);
    chk("sec open", rv[1], 1'b1);
    run(CMD_SECLOCK, 21'h000080, 16'h0);
    rdd(CMD_IDRD, 21'h000080);
    chk("sec locked", rv[1], 1'b0);
    $display("test sec done");
  endtask : t_sec

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Hang guard; the whole run needs far fewer cycles than this.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_por();
    t_prog_erase();
    t_lock();
    t_cfg_reset();
    t_vpp();
    t_susp();
    t_sec();
    end_sim();
  end
endmodule : fsl_host_tb_top
